/* File: scg_clock_gen.sv */
// core clock and peripheral bus clock enable generator
//
// Operation
// - The reference is an 8 MHz crystal, primary oscillator in crystal mode.
// - Core rate is reference / input divide * multiply / output divide.
// - The chain gives a range of core rates, never above 80 MHz.
// - The core clock serves the CPU, DMA, interrupt controller and cache.
// - The three PLL factors come from separate non-volatile fields.
// - The peripheral bus clock is the core clock divided by 1, 2, 4 or 8.
// - The peripheral bus clock serves timers and serial controllers.
// - Primary with PLL, /2, x20, /1 and /8 give an 80 MHz core clock.
`timescale 1ns/10ps
`default_nettype none
`include "scg_regs.svh"

module scg_clock_gen (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic xtal_i,
    input wire logic [1:0] primary_osc_mode_i,
    input wire logic [2:0] oscillator_source_select_i,
    input wire logic [`SCG_IDIV_W-1:0] pll_input_divide_i,
    input wire logic [`SCG_MUL_W-1:0] pll_multiply_factor_i,
    input wire logic [`SCG_ODIV_W-1:0] pll_output_divide_i,
    input wire logic [`SCG_PDIV_W-1:0] peripheral_clock_divide_i,
    output logic core_clock_en_o,
    output logic peripheral_bus_clock_en_o,
    output logic osc_running_o,
    output logic clock_valid_o,
    output logic config_error_o
);
    import scg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    scg_regs_type cur_ff;
    scg_regs_type nxt_regs;
    logic osc_ok;
    logic [`SCG_ACC_W:0] sum;
    logic [`SCG_ACC_W-1:0] modulus_new;
    logic [`SCG_ACC_W-1:0] inc_new;
    logic [2:0] pb_mask;
    logic bad_cfg;

    // crystal counts as running while edges keep arriving; the gap
    // counter parks at the limit when lost and one past it when armed
    assign osc_ok = cur_ff.gap < `SCG_GAP_W'(`SCG_OSC_GAP_CYC);

    // core rate in sys cycles: tick when acc wraps, inc/modulus of 200 MHz
    assign modulus_new = `SCG_SYS_MHZ * `SCG_ACC_W'(pll_input_divide_i)
        * `SCG_ACC_W'(pll_output_divide_i);
    assign inc_new = `SCG_XTAL_MHZ * `SCG_ACC_W'(pll_multiply_factor_i);
    assign pb_mask = 3'((4'h1 << cur_ff.pdiv) - 4'h1);

    // zero factors or rates above the ceiling would give no usable clock
    assign bad_cfg = (pll_input_divide_i == `SCG_IDIV_W'h0)
        || (pll_output_divide_i == `SCG_ODIV_W'h0)
        || (pll_multiply_factor_i == `SCG_MUL_W'h0)
        || (inc_new > `SCG_MAX_CORE_MHZ * `SCG_ACC_W'(pll_input_divide_i)
            * `SCG_ACC_W'(pll_output_divide_i))
        || (primary_osc_mode_i != `SCG_MODE_CRYSTAL_RANGE)
        || (oscillator_source_select_i != `SCG_SRC_PRIMARY_WITH_PLL);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        sum = '0;
        nxt_regs = cur_ff;
        nxt_regs.sync1 = xtal_i;
        nxt_regs.sync2 = cur_ff.sync1;
        nxt_regs.sync3 = cur_ff.sync2;
        nxt_regs.core_tick = 1'b0;
        nxt_regs.pb_tick = 1'b0;
        if (cur_ff.sync2 != cur_ff.sync3) begin
            // after loss one edge only arms: the sync chain leaves reset
            // at 0, so a crystal parked high would fake a lone edge
            if (cur_ff.gap == `SCG_GAP_W'(`SCG_OSC_GAP_CYC)) begin
                nxt_regs.gap = `SCG_GAP_W'(`SCG_OSC_ARMED_CYC);
            end else begin
                nxt_regs.gap = '0;
            end
        end else if (osc_ok) begin
            nxt_regs.gap = cur_ff.gap + `SCG_GAP_W'h1;
        end
        case (cur_ff.state)
            SCG_ST_LOAD: begin
                // one capture after reset; fields never change later
                nxt_regs.idiv = pll_input_divide_i;
                nxt_regs.mul = pll_multiply_factor_i;
                nxt_regs.odiv = pll_output_divide_i;
                nxt_regs.pdiv = peripheral_clock_divide_i;
                nxt_regs.modulus = modulus_new;
                nxt_regs.inc = inc_new;
                nxt_regs.cfg_err = bad_cfg;
                nxt_regs.state = bad_cfg ? SCG_ST_HALT : SCG_ST_WAIT_OSC;
            end
            SCG_ST_WAIT_OSC: begin
                nxt_regs.acc = '0;
                nxt_regs.pb_cnt = 3'h0;
                if (osc_ok) begin
                    nxt_regs.state = SCG_ST_RUN;
                end
            end
            SCG_ST_RUN: begin
                if (!osc_ok) begin
                    nxt_regs.state = SCG_ST_WAIT_OSC;
                end else begin
                    sum = {1'b0, cur_ff.acc} + {1'b0, cur_ff.inc};
                    if (sum >= {1'b0, cur_ff.modulus}) begin
                        // one enable serves cpu, dma, intc and cache
                        nxt_regs.acc = `SCG_ACC_W'(sum
                            - {1'b0, cur_ff.modulus});
                        nxt_regs.core_tick = 1'b1;
                        nxt_regs.pb_cnt = (cur_ff.pb_cnt + 3'h1) & pb_mask;
                        // timers and serial units use this enable
                        nxt_regs.pb_tick = cur_ff.pb_cnt == pb_mask;
                    end else begin
                        nxt_regs.acc = sum[`SCG_ACC_W-1:0];
                    end
                end
            end
            default: begin
                nxt_regs.state = SCG_ST_HALT;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cur_ff <= '{state: SCG_ST_LOAD, gap: `SCG_GAP_W'(`SCG_OSC_GAP_CYC),
                default: '0};
        end else begin
            cur_ff <= nxt_regs;
        end
    end

    assign core_clock_en_o = cur_ff.core_tick;
    assign peripheral_bus_clock_en_o = cur_ff.pb_tick;
    assign osc_running_o = osc_ok;
    assign clock_valid_o = cur_ff.state == SCG_ST_RUN;
    assign config_error_o = cur_ff.cfg_err;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_pb_quiet7;
        !cur_ff.pb_tick [*7];
    endsequence

    sequence s_pb_quiet3;
        !cur_ff.pb_tick [*3];
    endsequence

    // 80 of 200 MHz allows gaps of two, but never three ticks in five
    sequence s_core_pair;
        cur_ff.core_tick ##2 cur_ff.core_tick;
    endsequence

    sequence s_core_quiet2;
        !cur_ff.core_tick [*2];
    endsequence

    a_tick_needs_run: assert property (
        cur_ff.core_tick
        |-> $past(cur_ff.state) == SCG_ST_RUN && !cur_ff.cfg_err)
        else $error("core tick outside run state");
    a_valid_has_osc: assert property (
        $rose(cur_ff.state == SCG_ST_RUN) |-> $past(osc_ok))
        else $error("run entered without a running crystal");
    a_core_rate_cap: assert property (
        cur_ff.core_tick |=> !cur_ff.core_tick)
        else $error("core ticks in adjacent cycles");
    a_core_burst_cap: assert property (
        s_core_pair |=> s_core_quiet2)
        else $error("more than two core ticks in five cycles");
    a_acc_in_range: assert property (
        cur_ff.state == SCG_ST_RUN |-> cur_ff.acc < cur_ff.modulus)
        else $error("rate accumulator out of range");
    a_cfg_held: assert property (
        cur_ff.state != SCG_ST_LOAD && $past(cur_ff.state) != SCG_ST_LOAD
        |-> $stable(cur_ff.mul) && $stable(cur_ff.idiv)
            && $stable(cur_ff.odiv) && $stable(cur_ff.pdiv))
        else $error("configuration changed after reset capture");
    a_err_halts: assert property (
        cur_ff.cfg_err |-> cur_ff.state == SCG_ST_HALT && !cur_ff.core_tick)
        else $error("clock running with bad configuration");
    a_halt_sticks: assert property (
        cur_ff.state == SCG_ST_HALT |=> cur_ff.state == SCG_ST_HALT)
        else $error("halt left without reset");
    a_err_held: assert property (
        cur_ff.state != SCG_ST_LOAD && $past(cur_ff.state) != SCG_ST_LOAD
        |-> $stable(cur_ff.cfg_err) && $stable(cur_ff.modulus)
            && $stable(cur_ff.inc))
        else $error("captured rate changed before reset");
    a_wait_no_tick: assert property (
        cur_ff.state == SCG_ST_WAIT_OSC |=> !cur_ff.core_tick)
        else $error("core tick while waiting for crystal");
    a_pb_in_core: assert property (
        cur_ff.pb_tick |-> cur_ff.core_tick)
        else $error("peripheral tick without core tick");
    a_pb_div_one: assert property (
        cur_ff.pdiv == 2'h0 && cur_ff.core_tick |-> cur_ff.pb_tick)
        else $error("divide by one missed a tick");
    a_pb_div_eight: assert property (
        cur_ff.pdiv == 2'h3 && cur_ff.pb_tick |=> s_pb_quiet7)
        else $error("divide by eight too fast");
    a_pb_div_two: assert property (
        cur_ff.pdiv == 2'h1 && cur_ff.pb_tick |=> s_pb_quiet3)
        else $error("divide by two too fast");
    a_pb_div_four: assert property (
        cur_ff.pdiv == 2'h2 && cur_ff.pb_tick |=> s_pb_quiet7)
        else $error("divide by four too fast");
    a_example_cfg: assert property (
        cur_ff.state == SCG_ST_RUN && cur_ff.idiv == 4'h2
        && cur_ff.mul == 6'h14 && cur_ff.odiv == 4'h1
        |-> cur_ff.modulus == 16'h0190 && cur_ff.inc == 16'h00a0)
        else $error("example setting does not give 80 MHz");
    a_osc_loss: assert property (
        cur_ff.state == SCG_ST_RUN && !osc_ok
        |=> cur_ff.state == SCG_ST_WAIT_OSC ##1 !cur_ff.core_tick)
        else $error("clock kept running without crystal");

endmodule
`default_nettype wire

/* File: scg_regs.svh */
// constants of the system and peripheral clock generator
`ifndef SCG_REGS_SVH
`define SCG_REGS_SVH

`define SCG_CLK_PERIOD_NS 8'h05
`define SCG_SYS_MHZ 16'h00c8
`define SCG_XTAL_MHZ 16'h0008
`define SCG_MAX_CORE_MHZ 16'h0050
`define SCG_OSC_GAP_NS 8'h64
`define SCG_OSC_GAP_CYC (`SCG_OSC_GAP_NS / `SCG_CLK_PERIOD_NS)
`define SCG_OSC_ARMED_CYC (`SCG_OSC_GAP_CYC + 8'h01)
`define SCG_MODE_CRYSTAL_RANGE 2'h1
`define SCG_SRC_PRIMARY_WITH_PLL 3'h3
`define SCG_IDIV_W 4
`define SCG_MUL_W 6
`define SCG_ODIV_W 4
`define SCG_PDIV_W 2
`define SCG_ACC_W 16
`define SCG_GAP_W 6

`endif

/* File: scg_pkg.sv */
// types of the system and peripheral clock generator
`default_nettype none
`include "scg_regs.svh"

package scg_pkg;

    typedef enum logic [1:0] {
        SCG_ST_LOAD = 2'h0,
        SCG_ST_WAIT_OSC = 2'h1,
        SCG_ST_RUN = 2'h3,
        SCG_ST_HALT = 2'h2
    } scg_state_type;

    typedef struct packed {
        scg_state_type state;
        logic sync1;
        logic sync2;
        logic sync3;
        logic [`SCG_GAP_W-1:0] gap;
        logic [`SCG_IDIV_W-1:0] idiv;
        logic [`SCG_MUL_W-1:0] mul;
        logic [`SCG_ODIV_W-1:0] odiv;
        logic [`SCG_PDIV_W-1:0] pdiv;
        logic cfg_err;
        logic [`SCG_ACC_W-1:0] modulus;
        logic [`SCG_ACC_W-1:0] inc;
        logic [`SCG_ACC_W-1:0] acc;
        logic [2:0] pb_cnt;
        logic core_tick;
        logic pb_tick;
    } scg_regs_type;

endpackage
`default_nettype wire

/* File: scg_xtal_model.sv */
// crystal reference model for the clock generator
`timescale 1ns/10ps
`default_nettype none
module scg_xtal_model #(
    parameter real HALF_NS = 62.5
) (
    input wire logic run_i,
    output logic xtal_o
);
    logic lvl = 1'b0;
    assign xtal_o = lvl;
    // a dead crystal holds its level, so loss shows only as missing edges
    always begin
        #(HALF_NS);
        if (run_i) lvl = ~lvl;
    end
endmodule
`default_nettype wire

/* File: scg_clock_gen_tb.sv */
// self-checking bench of the clock generator
`timescale 1ns/10ps
`default_nettype none
`include "scg_regs.svh"
module scg_clock_gen_tb;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic run = 1'b0;
    logic xtal;
    logic [1:0] md = 2'h1;
    logic [2:0] sr = 3'h3;
    logic [3:0] id = 4'h2;
    logic [5:0] mu = 6'h14;
    logic [3:0] od = 4'h1;
    logic [1:0] pd = 2'h0;
    logic ce, pe, osc, vld, err;
    int num_errors = 0;
    int checked = 0;
    int seed = 32'h2a26;
    int q[$];
    int cyc = 0;
    int inc = 0;
    bit go = 0;
    bit done = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) cyc <= cyc + 1;
    scg_xtal_model xtal_u (.run_i(run), .xtal_o(xtal));
    scg_clock_gen dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .xtal_i(xtal), .primary_osc_mode_i(md),
        .oscillator_source_select_i(sr), .pll_input_divide_i(id),
        .pll_multiply_factor_i(mu), .pll_output_divide_i(od),
        .peripheral_clock_divide_i(pd), .core_clock_en_o(ce),
        .peripheral_bus_clock_en_o(pe), .osc_running_o(osc),
        .clock_valid_o(vld), .config_error_o(err));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cfg(logic [1:0] m, logic [2:0] s, logic [3:0] i,
        logic [5:0] u, logic [3:0] o, logic [1:0] p, bit bad);
        int n;
        reset_n_i = 1'b0;
        {md, sr, id, mu, od, pd} = {m, s, i, u, o, p};
        repeat (2) @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        q.push_back(bad);
        q.push_back(200 * i * o);
        q.push_back((1 << p) - 1);
        inc = 8 * u;
        go = 1;
        repeat (3) @(negedge clk_sys_i);
        // straps wander after capture; rates must not follow
        {id, mu, od, pd} = 16'($random(seed));
        for (n = 0; !done; n++) begin
            @(negedge clk_sys_i);
            if (n > 4000) begin
                check("timeout", 0, 1);
                summarize();
            end
        end
        go = 0;
        done = 0;
        $display("test done %0h %0h %0h %0h %0h %0h", m, s, i, u, o, p);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin : watch
        int t0, k, pk, sp;
        forever begin
            wait (go);
            repeat (2) @(posedge clk_sys_i);
            #1 check("config_error", err, q.pop_front());
            {k, pk, sp, t0} = {32'sd0, -32'sd1, 32'sd0, 32'sd0};
            for (int n = 0; n < 3000 && k <= inc; n++) begin
                @(posedge clk_sys_i);
                #1;
                if (err === 1'b1)
                    check("halted", {vld, ce, pe}, 3'h0);
                if (err !== 1'b1 && ce === 1'b1) begin
                    if (k == 0) t0 = cyc;
                    if (k == inc) sp = cyc - t0;
                    if (pe === 1'b1 && pk < 0) pk = k;
                    k++;
                end
            end
            if (err === 1'b1) void'(q.pop_front());
            else check("core_span", sp, q.pop_front());
            if (err === 1'b1) void'(q.pop_front());
            else check("pb_first", pk, q.pop_front());
            if (err !== 1'b1) check("running", {osc, vld}, 2'h3);
            done = 1;
            wait (!go);
        end
    end
    initial begin : drive
        logic [3:0] i, o;
        repeat (2) @(negedge clk_sys_i);
        run = 1'b1;
        for (int p = 0; p < 4; p++) cfg(1, 3, 2, 20, 1, 2'(p), 0);
        repeat (3) begin
            i = 4'(1 + $unsigned($random(seed)) % 3);
            o = 4'(1 + $unsigned($random(seed)) % 2);
            // only working combinations are offered here
            cfg(1, 3, i, 6'(1 + $unsigned($random(seed)) % (10 * i * o)),
                o, 2'($random(seed)), 0);
        end
        cfg(2, 3, 2, 20, 1, 0, 1);
        cfg(1, 1, 2, 20, 1, 0, 1);
        cfg(1, 3, 0, 20, 1, 0, 1);
        cfg(1, 3, 2, 0, 1, 0, 1);
        cfg(1, 3, 2, 20, 0, 0, 1);
        cfg(1, 3, 1, 11, 1, 0, 1);
        cfg(1, 3, 1, 10, 1, 1, 0);
        run = 1'b0;
        repeat (30) @(negedge clk_sys_i);
        check("lost", {osc, vld}, 2'h0);
        repeat (50) @(negedge clk_sys_i) check("stopped", ce, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
